// ### src/gated_timer_block.sv
// Top: APB registers, shared oscillator, pin synchronisers, timers
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module gated_timer_block
   import gated_timer_pkg::*;
#(
   parameter int unsigned NUM_TIMERS = 3
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [ADDR_W-1:0]     i_paddr,
   input  wire logic [31:0]           i_pwdata,
   output logic      [31:0]           o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr,
   input  wire logic                  i_sleep,
   input  wire logic [NUM_TIMERS-1:0] i_ext_clock_pin,
   input  wire logic [NUM_TIMERS-1:0] i_gate_pin,
   input  wire logic                  i_sec_osc_in_pin,
   output logic                       o_sec_osc_out_pin,
   output logic                       o_sec_osc_run,
   output logic      [NUM_TIMERS-1:0] o_overflow_irq,
   output logic                       o_wake
);
   //==================================================================
   // Elaboration check
   if (NUM_TIMERS < 1 || NUM_TIMERS > MAX_TIMERS) begin : g_bad_count
      $error("NUM_TIMERS must lie between 1 and MAX_TIMERS");
   end

   localparam int unsigned PINS = 2 * NUM_TIMERS + 1;

   //==================================================================
   // Address decode; inst_hit shared by read and write paths, shared_hit read only
   function automatic logic inst_hit(input logic [ADDR_W-1:0] a);
      inst_hit = (a[7:6] == 2'h0) && (32'(a[5:4]) < NUM_TIMERS)
                 && (a[1:0] == 2'h0);
   endfunction : inst_hit

   function automatic logic shared_hit(input logic [ADDR_W-1:0] a);
      shared_hit = (a == OFS_OSC_CONTROL_TWO) || (a == OFS_OSC_CONTROL)
                   || (a == OFS_STATUS) || (a == OFS_OVF_ENABLE);
   endfunction : shared_hit

   //==================================================================
   // Pin synchronisers; first stage feeds only the second
   logic [PINS-1:0] pin_meta;
   logic [PINS-1:0] pin_stable;
   logic [PINS-1:0] pin_prev;
   logic [PINS-1:0] pin_raw;
   logic [PINS-1:0] pin_rise;
   logic [PINS-1:0] pin_fall;

   always_comb begin
      pin_raw  = {i_gate_pin, i_ext_clock_pin, i_sec_osc_in_pin};
      pin_rise = pin_stable & ~pin_prev;
      pin_fall = ~pin_stable & pin_prev;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_meta   <= '0;
         pin_stable <= '0;
         pin_prev   <= '0;
      end else begin
         pin_meta   <= pin_raw;
         pin_stable <= pin_meta;
         pin_prev   <= pin_stable;
      end
   end

   //==================================================================
   // Register state
   logic [7:0]            timer_control [NUM_TIMERS];
   logic [7:0]            next_timer_control [NUM_TIMERS];
   logic [7:0]            gate_control [NUM_TIMERS];
   logic [7:0]            next_gate_control [NUM_TIMERS];
   logic                  sec_osc_go;
   logic                  next_sec_osc_go;
   logic [1:0]            system_clock_select;
   logic [1:0]            next_system_clock_select;
   logic [NUM_TIMERS-1:0] ovf_flag;
   logic [NUM_TIMERS-1:0] next_ovf_flag;
   logic [NUM_TIMERS-1:0] ovf_enable;
   logic [NUM_TIMERS-1:0] next_ovf_enable;
   logic [31:0]           prdata;
   logic [31:0]           next_prdata;
   logic                  pslverr;
   logic                  next_pslverr;
   logic [1:0]            instr_phase;
   logic [1:0]            next_instr_phase;
   logic                  osc_run;
   logic                  next_osc_run;
   logic                  osc_out;
   logic                  next_osc_out;
   logic                  wake;
   logic                  next_wake;

   //==================================================================
   // Per-timer wiring
   logic [15:0]           count [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] ovf_pulse;
   logic [NUM_TIMERS-1:0] write_low;
   logic [NUM_TIMERS-1:0] write_high;
   logic [NUM_TIMERS-1:0] count_enable;
   logic [NUM_TIMERS-1:0] ext_mode;
   logic [NUM_TIMERS-1:0] src_rise;
   logic [NUM_TIMERS-1:0] src_fall;
   logic [NUM_TIMERS-1:0] int_tick;
   logic [NUM_TIMERS-1:0] sosc_request;
   logic                  instr_tick;
   logic                  setup;
   logic                  wr_access;

   //==================================================================
   // Instruction clock, shared oscillator, source selection
   always_comb begin
      // Instruction clock halts in Sleep, so aligned counting stops too
      next_instr_phase = i_sleep ? instr_phase : instr_phase + 2'h1;
      instr_tick = (instr_phase == INSTR_PHASE_LAST) & ~i_sleep;
      for (int i = 0; i < NUM_TIMERS; i++) begin
         sosc_request[i] = timer_control[i][TC_SOSC_EN_BIT];
      end
      // No Sleep term: the oscillator ignores the core's Sleep state
      next_osc_run = (|sosc_request) | sec_osc_go
                     | (system_clock_select == SCS_SEC_OSC);
      // Inverting amplifier output toward the crystal
      next_osc_out = osc_run & ~pin_stable[0];
      for (int i = 0; i < NUM_TIMERS; i++) begin
         ext_mode[i] = (timer_control[i][TC_CS_LSB +: 2] == CS_EXTERNAL);
         if (sosc_request[i]) begin
            src_rise[i] = pin_rise[0] & osc_run;
            src_fall[i] = pin_fall[0] & osc_run;
         end else begin
            src_rise[i] = pin_rise[1 + i];
            src_fall[i] = pin_fall[1 + i];
         end
         unique case (timer_control[i][TC_CS_LSB +: 2])
            CS_SYSTEM: int_tick[i] = ~i_sleep;
            CS_INSTR:  int_tick[i] = instr_tick;
            default:   int_tick[i] = 1'b0;
         endcase
         count_enable[i] = timer_control[i][TC_ON_BIT]
            & (~gate_control[i][GC_EN_BIT]
               | (pin_stable[1 + NUM_TIMERS + i]
                  == gate_control[i][GC_POL_BIT]));
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         instr_phase <= 2'h0;
         osc_run     <= 1'b0;
         osc_out     <= 1'b0;
      end else begin
         instr_phase <= next_instr_phase;
         osc_run     <= next_osc_run;
         osc_out     <= next_osc_out;
      end
   end

   //==================================================================
   // APB slave: read data sampled in setup, write at access edge
   always_comb begin
      setup     = i_psel & ~i_penable;
      wr_access = i_psel & i_penable & i_pwrite;
      next_timer_control       = timer_control;
      next_gate_control        = gate_control;
      next_sec_osc_go          = sec_osc_go;
      next_system_clock_select = system_clock_select;
      next_ovf_enable          = ovf_enable;
      next_prdata              = prdata;
      next_pslverr             = pslverr;
      write_low                = '0;
      write_high               = '0;
      // Hardware set beats a same-cycle software clear
      next_ovf_flag = ovf_flag;
      if (wr_access && i_paddr == OFS_STATUS) begin
         next_ovf_flag = ovf_flag & ~i_pwdata[NUM_TIMERS-1:0];
      end
      next_ovf_flag = next_ovf_flag | ovf_pulse;
      next_wake = (|ovf_pulse) & i_sleep;
      if (wr_access && inst_hit(i_paddr)) begin
         for (int i = 0; i < NUM_TIMERS; i++) begin
            if (32'(i_paddr[5:4]) == i) begin
               unique case (i_paddr[3:0])
                  OFS_TIMER_CONTROL: next_timer_control[i] = i_pwdata[7:0];
                  OFS_GATE_CONTROL:  next_gate_control[i]  = i_pwdata[7:0];
                  OFS_COUNT_LOW:     write_low[i]  = 1'b1;
                  OFS_COUNT_HIGH:    write_high[i] = 1'b1;
                  default: ;
               endcase
            end
         end
      end
      if (wr_access && i_paddr == OFS_OSC_CONTROL_TWO) begin
         next_sec_osc_go = i_pwdata[OC2_GO_BIT];
      end
      if (wr_access && i_paddr == OFS_OSC_CONTROL) begin
         next_system_clock_select = i_pwdata[1:0];
      end
      if (wr_access && i_paddr == OFS_OVF_ENABLE) begin
         next_ovf_enable = i_pwdata[NUM_TIMERS-1:0];
      end
      if (setup) begin
         next_prdata  = 32'h00000000;
         next_pslverr = ~(inst_hit(i_paddr) | shared_hit(i_paddr));
         if (inst_hit(i_paddr)) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
               if (32'(i_paddr[5:4]) == i) begin
                  unique case (i_paddr[3:0])
                     OFS_TIMER_CONTROL:
                        next_prdata = {24'h000000, timer_control[i]};
                     OFS_GATE_CONTROL:
                        next_prdata = {24'h000000, gate_control[i]};
                     OFS_COUNT_LOW:
                        next_prdata = {24'h000000, count[i][7:0]};
                     OFS_COUNT_HIGH:
                        next_prdata = {24'h000000, count[i][15:8]};
                     default: ;
                  endcase
               end
            end
         end
         unique case (i_paddr)
            OFS_OSC_CONTROL_TWO: next_prdata = {31'h00000000, sec_osc_go};
            OFS_OSC_CONTROL:
               next_prdata = {30'h00000000, system_clock_select};
            OFS_STATUS: begin
               next_prdata[NUM_TIMERS-1:0]  = ovf_flag;
               next_prdata[ST_OSC_RUN_BIT]  = osc_run;
            end
            OFS_OVF_ENABLE: next_prdata[NUM_TIMERS-1:0] = ovf_enable;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < NUM_TIMERS; i++) begin
            timer_control[i] <= RST_TIMER_CONTROL;
            gate_control[i]  <= RST_GATE_CONTROL;
         end
         sec_osc_go          <= 1'b0;
         system_clock_select <= 2'h0;
         ovf_flag            <= '0;
         ovf_enable          <= '0;
         prdata              <= 32'h00000000;
         pslverr             <= 1'b0;
         wake                <= 1'b0;
      end else begin
         timer_control       <= next_timer_control;
         gate_control        <= next_gate_control;
         sec_osc_go          <= next_sec_osc_go;
         system_clock_select <= next_system_clock_select;
         ovf_flag            <= next_ovf_flag;
         ovf_enable          <= next_ovf_enable;
         prdata              <= next_prdata;
         pslverr             <= next_pslverr;
         wake                <= next_wake;
      end
   end

   //==================================================================
   // Timer instances, each able to run from the one oscillator
   for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
      gated_timer_core u_core (
         .i_clk             (i_clk),
         .i_rst_b           (i_rst_b),
         .i_timer_on        (timer_control[g][TC_ON_BIT]),
         .i_count_enable    (count_enable[g]),
         .i_ext_mode        (ext_mode[g]),
         .i_no_sync         (timer_control[g][TC_NO_SYNC_BIT]),
         .i_src_rise        (src_rise[g]),
         .i_src_fall        (src_fall[g]),
         .i_int_tick        (int_tick[g]),
         .i_instr_tick      (instr_tick),
         .i_prescale_select (timer_control[g][TC_PS_LSB +: 2]),
         .i_write_low       (write_low[g]),
         .i_write_high      (write_high[g]),
         .i_wdata           (i_pwdata[7:0]),
         .o_count           (count[g]),
         .o_overflow        (ovf_pulse[g])
      );
   end

   //==================================================================
   // Outputs
   assign o_prdata          = prdata;
   assign o_pready          = 1'b1;
   assign o_pslverr         = pslverr;
   assign o_sec_osc_out_pin = osc_out;
   assign o_sec_osc_run     = osc_run;
   assign o_overflow_irq    = ovf_flag & ovf_enable;
   assign o_wake            = wake;
endmodule : gated_timer_block
`default_nettype wire

// ### src/gated_timer_core.sv
// One timer instance: arming, alignment, prescaler and 16-bit counter
`timescale 1ns/1ps
`default_nettype none
module gated_timer_core
   import gated_timer_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_timer_on,
   input  wire logic        i_count_enable,
   input  wire logic        i_ext_mode,
   input  wire logic        i_no_sync,
   input  wire logic        i_src_rise,
   input  wire logic        i_src_fall,
   input  wire logic        i_int_tick,
   input  wire logic        i_instr_tick,
   input  wire logic [1:0]  i_prescale_select,
   input  wire logic        i_write_low,
   input  wire logic        i_write_high,
   input  wire logic [7:0]  i_wdata,
   output logic      [15:0] o_count,
   output logic             o_overflow
);
   //==================================================================
   // State
   logic [15:0] count;
   logic [15:0] next_count;
   logic [2:0]  prescale;
   logic [2:0]  next_prescale;
   logic        armed;
   logic        next_armed;
   logic        pending;
   logic        next_pending;
   logic        overflow;
   logic        next_overflow;
   logic        write_any;
   logic        ext_edge;
   logic        tick;
   logic        inc;
   logic [2:0]  prescale_last;

   //==================================================================
   // Next state
   always_comb begin
      write_any = i_write_low | i_write_high;
      // Disabled, rewritten or left external mode: wait for a fall
      next_armed = armed;
      if (!i_timer_on || write_any || !i_ext_mode) begin
         next_armed = 1'b0;
      end else if (i_src_fall) begin
         next_armed = 1'b1;
      end
      ext_edge = i_ext_mode & armed & i_src_rise;
      // Aligned edge waits for the instruction tick; dropped when off, rewritten or no_sync set
      next_pending = (pending & ~i_instr_tick) | (ext_edge & ~i_no_sync);
      if (!i_timer_on || write_any || i_no_sync) begin
         next_pending = 1'b0;
      end
      tick = i_count_enable & (i_int_tick
             | (ext_edge & i_no_sync)
             | (pending & i_instr_tick & ~i_no_sync));
      unique case (i_prescale_select)
         2'h0: prescale_last = 3'h0;
         2'h1: prescale_last = 3'h1;
         2'h2: prescale_last = 3'h3;
         2'h3: prescale_last = 3'h7;
      endcase
      inc = 1'b0;
      next_prescale = prescale;
      if (write_any) begin
         next_prescale = 3'h0;
      end else if (tick) begin
         if (prescale >= prescale_last) begin
            next_prescale = 3'h0;
            inc = 1'b1;
         end else begin
            next_prescale = prescale + 3'h1;
         end
      end
      next_count = count;
      next_overflow = 1'b0;
      if (i_write_low) begin
         next_count = {count[15:8], i_wdata};
      end else if (i_write_high) begin
         next_count = {i_wdata, count[7:0]};
      end else if (inc) begin
         next_count = count + 16'h0001;
         next_overflow = (count == COUNT_ALL_ONES);
      end
   end

   //==================================================================
   // Registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count    <= RST_COUNT;
         prescale <= 3'h0;
         armed    <= 1'b0;
         pending  <= 1'b0;
         overflow <= 1'b0;
      end else begin
         count    <= next_count;
         prescale <= next_prescale;
         armed    <= next_armed;
         pending  <= next_pending;
         overflow <= next_overflow;
      end
   end

   assign o_count    = count;
   assign o_overflow = overflow;
endmodule : gated_timer_core
`default_nettype wire

// ### src/gated_timer_pkg.sv
// Register map, field positions and reset values of the gated timer block
//=====================================================================
// Contract
// - Sixteen-bit up counter seen as two bytes; byte writes load it at once.
// - Off when timer_on is 0; gate_enable makes counting follow the gate.
// - clock_select 01 system, 00 instruction, 10 pin or oscillator.
// - One secondary oscillator shared; any sec_osc_enable starts and selects.
// - Internal source counts instruction cycles through the prescaler.
// - System clock source adds four counts per instruction cycle.
// - External pin counts rising edges, synchronised or not.
// - External mode needs a falling edge before the first counted rise.
// - Prescaler divides the selected source by 1, 2, 4 or 8.
// - Prescale counter hidden; cleared by any count byte write.
// - Oscillator runs on any sec_osc_enable, sec_osc_go or select 01.
// - Oscillator keeps running through Sleep.
// - no_sync passes the external edge without instruction alignment.
// - Async external counting runs in Sleep; overflow wakes the core.
// - Sync to async may lose one count; async to sync may add one.
// - Gated mode counts only while gate level equals gate_polarity.
package gated_timer_pkg;
   //==================================================================
   // Address map
   localparam int unsigned ADDR_W           = 8;
   localparam int unsigned MAX_TIMERS       = 4;
   localparam logic [3:0]  OFS_TIMER_CONTROL = 4'h0;
   localparam logic [3:0]  OFS_GATE_CONTROL  = 4'h4;
   localparam logic [3:0]  OFS_COUNT_LOW     = 4'h8;
   localparam logic [3:0]  OFS_COUNT_HIGH    = 4'hC;
   localparam logic [7:0]  OFS_OSC_CONTROL_TWO = 8'h40;
   localparam logic [7:0]  OFS_OSC_CONTROL     = 8'h44;
   localparam logic [7:0]  OFS_STATUS          = 8'h48;
   localparam logic [7:0]  OFS_OVF_ENABLE      = 8'h4C;
   //==================================================================
   // Field positions
   localparam int unsigned TC_ON_BIT      = 0;
   localparam int unsigned TC_NO_SYNC_BIT = 2;
   localparam int unsigned TC_SOSC_EN_BIT = 3;
   localparam int unsigned TC_PS_LSB      = 4;
   localparam int unsigned TC_CS_LSB      = 6;
   localparam int unsigned GC_POL_BIT     = 6;
   localparam int unsigned GC_EN_BIT      = 7;
   localparam int unsigned OC2_GO_BIT     = 0;
   localparam int unsigned ST_OSC_RUN_BIT = 8;
   //==================================================================
   // Encodings and reset values
   localparam logic [1:0]  CS_INSTR     = 2'h0;
   localparam logic [1:0]  CS_SYSTEM    = 2'h1;
   localparam logic [1:0]  CS_EXTERNAL  = 2'h2;
   localparam logic [1:0]  SCS_SEC_OSC  = 2'h1;
   localparam logic [1:0]  INSTR_PHASE_LAST = 2'h3;
   localparam logic [7:0]  RST_TIMER_CONTROL = 8'h00;
   localparam logic [7:0]  RST_GATE_CONTROL  = 8'h00;
   localparam logic [15:0] RST_COUNT         = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES    = 16'hFFFF;
endpackage : gated_timer_pkg

// ### tb/tb_top.sv
// Self-checking bench of the gated timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   err_total++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top import gated_timer_pkg::*; ;
   //==================================================================
   // Signals and instances
   logic        i_clk = 1'b0, i_rst_b = 1'b0, sleep = 1'b0, woke = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        pready, pslverr, rerr, osc_in, osc_out, osc_run, wake;
   logic [2:0]  ext, gate, irq;
   int          err_total = 0, comparisons = 0, i;
   logic [7:0]  oa [3] = '{OFS_OSC_CONTROL_TWO, OFS_OSC_CONTROL, 8'h10};
   logic [31:0] od [3] = '{32'h1, 32'h1, 32'h8};
   always #2.5 i_clk = ~i_clk;
   always @(posedge i_clk) if (wake) woke <= 1'b1;
   gated_timer_block i_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_sleep(sleep), .i_ext_clock_pin(ext),
      .i_gate_pin(gate), .i_sec_osc_in_pin(osc_in),
      .o_sec_osc_out_pin(osc_out), .o_sec_osc_run(osc_run),
      .o_overflow_irq(irq), .o_wake(wake));
   timer_far_side i_far (
      .i_clk(i_clk), .i_osc_run(osc_run), .o_ext_clock_pin(ext),
      .o_gate_pin(gate), .o_osc_pin(osc_in));
   //==================================================================
   // Bus and helper tasks
   function automatic logic [7:0] ra(input logic [3:0] t, o);
      return {t, o};
   endfunction : ra
   function automatic logic [31:0] ctl(input logic [1:0] c, p,
                                       input logic [3:0] f);
      return {24'h0, c, p, f};
   endfunction : ctl
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge i_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1)
         @(posedge i_clk);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rng(input string nm, input int lo, hi);
      `CHK(nm, 1'b1, (rdata[7:0] >= lo && rdata[7:0] <= hi))
   endtask : rng
   task automatic run(input logic [3:0] t, input logic [31:0] c);
      apb(1'b1, ra(t, OFS_COUNT_LOW), 32'h0);
      apb(1'b1, ra(t, OFS_COUNT_HIGH), 32'h0);
      apb(1'b1, ra(t, OFS_TIMER_CONTROL), c);
      repeat (198) @(posedge i_clk);
      apb(1'b1, ra(t, OFS_TIMER_CONTROL), 32'h0);
      apb(1'b0, ra(t, OFS_COUNT_LOW), 32'h0);
   endtask : run
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   //==================================================================
   // Tests
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      apb(1'b0, ra(0, OFS_TIMER_CONTROL), 32'h0);
      `CHK("ctl_reset", {24'h0, RST_TIMER_CONTROL}, rdata)
      apb(1'b0, 8'h30, 32'h0);
      `CHK("unmapped", 1'b1, rerr)
      apb(1'b1, ra(1, OFS_COUNT_HIGH), 32'hA5);
      apb(1'b1, ra(1, OFS_COUNT_LOW), 32'h3C);
      apb(1'b0, ra(1, OFS_COUNT_HIGH), 32'h0);
      `CHK("cnt_high", 32'hA5, rdata)
      apb(1'b0, ra(1, OFS_COUNT_LOW), 32'h0);
      `CHK("cnt_low", 32'h3C, rdata)
      $display("bytes done");
      for (i = 0; i < 4; i++) begin
         run(0, ctl(CS_INSTR, i[1:0], 4'h1));
         rng("instr", 200 / (4 << i) - 1, 200 / (4 << i) + 1);
      end
      run(0, ctl(CS_SYSTEM, 2'h0, 4'h1));
      rng("system", 197, 203);
      run(0, ctl(CS_SYSTEM, 2'h0, 4'h0));
      rng("off", 0, 0);
      $display("clocks done");
      for (i = 0; i < 2; i++) begin
         apb(1'b1, ra(0, OFS_GATE_CONTROL), 32'h80 | (i << 6));
         i_far.set(1, 0, i[0]);
         run(0, ctl(CS_SYSTEM, 2'h0, 4'h1));
         rng("gate_open", 197, 203);
         i_far.set(1, 0, ~i[0]);
         run(0, ctl(CS_SYSTEM, 2'h0, 4'h1));
         rng("gate_shut", 0, 0);
      end
      apb(1'b1, ra(0, OFS_GATE_CONTROL), 32'h0);
      $display("gate done");
      apb(1'b1, ra(2, OFS_TIMER_CONTROL), ctl(CS_EXTERNAL, 2'h0, 4'h1));
      i_far.set(0, 2, 1'b0);
      apb(1'b1, ra(2, OFS_COUNT_LOW), 32'h0);
      // Rise right after the disarming count write must be ignored
      for (i = 1; i < 8; i++)
         i_far.set(0, 2, i[0]);
      repeat (8) @(posedge i_clk);
      apb(1'b0, ra(2, OFS_COUNT_LOW), 32'h0);
      `CHK("ext_count", 32'h3, rdata)
      apb(1'b1, ra(2, OFS_TIMER_CONTROL), ctl(CS_EXTERNAL, 2'h0, 4'h5));
      apb(1'b1, OFS_OVF_ENABLE, 32'h4);
      apb(1'b1, ra(2, OFS_COUNT_HIGH), 32'hFF);
      apb(1'b1, ra(2, OFS_COUNT_LOW), 32'hFF);
      sleep <= 1'b1;
      i_far.set(0, 2, 1'b0);
      i_far.set(0, 2, 1'b1);
      repeat (8) @(posedge i_clk);
      sleep <= 1'b0;
      `CHK("wake", 1'b1, woke)
      `CHK("irq", 3'h4, irq)
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("flag", 32'h4, rdata & 32'h7)
      apb(1'b1, OFS_STATUS, 32'h4);
      repeat (2) @(posedge i_clk);
      `CHK("irq_clear", 3'h0, irq)
      $display("counter done");
      for (i = 0; i < 3; i++) begin
         apb(1'b1, oa[i], od[i]);
         repeat (4) @(posedge i_clk);
         `CHK("osc_on", 1'b1, osc_run)
         apb(1'b1, oa[i], 32'h0);
         repeat (4) @(posedge i_clk);
         `CHK("osc_off", 1'b0, osc_run)
      end
      apb(1'b1, ra(1, OFS_TIMER_CONTROL), 32'h8);
      repeat (200) @(posedge i_clk);
      sleep <= 1'b1;
      run(1, ctl(CS_EXTERNAL, 2'h0, 4'hD));
      sleep <= 1'b0;
      rng("osc_count", 10, 14);
      $display("oscillator done");
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire

// ### tb/timer_checker.sv
// Port checker of the gated timer block
`timescale 1ns/1ps
`default_nettype none
module timer_checker
   import gated_timer_pkg::*;
#(
   parameter int unsigned NUM_TIMERS = 3
) (
   input wire logic                  i_clk,
   input wire logic                  i_rst_b,
   input wire logic                  i_psel,
   input wire logic                  i_penable,
   input wire logic                  i_pwrite,
   input wire logic [ADDR_W-1:0]     i_paddr,
   input wire logic [31:0]           o_prdata,
   input wire logic                  o_pready,
   input wire logic                  o_pslverr,
   input wire logic                  i_sleep,
   input wire logic                  o_sec_osc_out_pin,
   input wire logic                  o_sec_osc_run,
   input wire logic [NUM_TIMERS-1:0] o_overflow_irq,
   input wire logic                  o_wake
);
   wire wr = i_psel && i_penable && i_pwrite;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   //==================================================================
   // Bus answers
   sequence s_read;
      i_psel && !i_penable ##1 i_psel && i_penable;
   endsequence
   AST_READY: assert property (o_pready)
      else $error("pready low");
   AST_RDATA_HOLD: assert property (s_read |=> $stable(o_prdata))
      else $error("read data moved after access");
   AST_RDATA_CAUSE: assert property ($changed(o_prdata)
      |-> $past(i_psel && !i_penable)) else $error("read data moved");
   AST_ERR_MAP: assert property (i_psel && !i_penable && i_paddr[7:6] == 0
      |=> o_pslverr == (i_paddr[5:4] >= NUM_TIMERS || i_paddr[1:0] != 0))
      else $error("slave error wrong");
   //==================================================================
   // Oscillator, wake and flags
   AST_OSC_CAUSE: assert property ($changed(o_sec_osc_run)
      |-> $past(wr) || $past(wr, 2)) else $error("osc run moved");
   AST_OSC_PIN: assert property (o_sec_osc_out_pin
      |-> o_sec_osc_run || $past(o_sec_osc_run)) else $error("osc pin");
   AST_WAKE: assert property (o_wake |-> $past(i_sleep) ##1 !o_wake)
      else $error("wake pulse wrong");
   AST_IRQ_CLEAR: assert property (|(~o_overflow_irq
      & $past(o_overflow_irq)) |-> $past(wr)) else $error("irq fell");
endmodule : timer_checker
bind gated_timer_block timer_checker #(.NUM_TIMERS(NUM_TIMERS)) i_chk (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_sleep(i_sleep), .o_sec_osc_out_pin(o_sec_osc_out_pin),
   .o_sec_osc_run(o_sec_osc_run), .o_overflow_irq(o_overflow_irq),
   .o_wake(o_wake));
`default_nettype wire

// ### tb/timer_far_side.sv
// Far-side model: count pins, gate pins, crystal
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
   input  wire logic       i_clk,
   input  wire logic       i_osc_run,
   output logic      [2:0] o_ext_clock_pin,
   output logic      [2:0] o_gate_pin,
   output logic            o_osc_pin
);
   logic [2:0] div = 3'h0;
   initial begin
      o_ext_clock_pin = 3'h7;
      o_gate_pin      = 3'h0;
      o_osc_pin       = 1'b0;
   end
   //==================================================================
   // Crystal swings only while enabled, far slower than i_clk
   always @(posedge i_clk) begin
      div <= div + 3'h1;
      if (i_osc_run && div == 3'h7)
         o_osc_pin <= ~o_osc_pin;
   end
   //==================================================================
   // Slow pin change, well clear of the synchroniser delay
   task automatic set(input int g, input int k, input logic v);
      repeat (8) @(posedge i_clk);
      if (g != 0)
         o_gate_pin[k] <= v;
      else
         o_ext_clock_pin[k] <= v;
   endtask : set
endmodule : timer_far_side
`default_nettype wire
